//--- ihe_pkg.sv
// Constants, register layout and state type of the interrupt handler
package ihe_pkg;

  localparam int          NUM_SRC      = 12;
  localparam logic [7:0]  IE_ADDR      = 8'ha8;
  localparam logic [7:0]  EIE_ADDR     = 8'he6;
  localparam logic [7:0]  IE_RESET     = 8'h00;
  localparam logic [7:0]  EIE_RESET    = 8'h00;
  localparam logic [7:0]  IE_WMASK     = 8'hbf;
  localparam logic [7:0]  EIE_WMASK    = 8'h3f;
  localparam int          IE_GATE_BIT  = 7;
  localparam int          IE_T2_BIT    = 5;
  localparam int          IE_UART_BIT  = 4;
  localparam int          IE_T1_BIT    = 3;
  localparam int          IE_EX1_BIT   = 2;
  localparam int          IE_T0_BIT    = 1;
  localparam int          IE_EX0_BIT   = 0;
  localparam int          SRC_EX0      = 0;
  localparam int          SRC_T0       = 1;
  localparam int          SRC_EX1      = 2;
  localparam int          SRC_T1       = 3;
  localparam int          SRC_UART     = 4;
  localparam int          SRC_T2       = 5;
  localparam int          NUM_EXT_SRC  = 6;
  localparam logic [15:0] VEC_BASE     = 16'h0003;
  localparam int          VEC_SHIFT    = 3;
  localparam logic [11:0] AUTO_CLR_DEF = 12'h00f;
  localparam logic [1:0]  LAG_RESET    = 2'h0;
  localparam logic [1:0]  LAG_ARMED    = 2'h2;
  localparam logic [1:0]  LAG_LAST     = 2'h1;

  typedef struct packed {
    logic [7:0]  ie;
    logic [7:0]  eie;
    logic [11:0] pend;
    logic [1:0]  ext_meta;
    logic [1:0]  ext_sync;
    logic [1:0]  ext_prev;
    logic [1:0]  lag;
    logic        ins_lo;
    logic        ins_hi;
    logic        call;
    logic [15:0] vaddr;
    logic [3:0]  vsrc;
    logic [7:0]  rdata;
  } ihe_state_t;

endpackage

//--- ihe_handler.sv
// Interrupt handler with global and per-source enables, two priority levels
`timescale 1ns/1ps
module ihe_handler #(
  parameter logic [11:0] AUTO_CLR = ihe_pkg::AUTO_CLR_DEF
) (
  input  wire logic                        clk,
  input  wire logic                        reset_n,
  input  wire logic [7:0]                  sfr_addr,
  input  wire logic                        sfr_wr,
  input  wire logic                        sfr_rd,
  input  wire logic [7:0]                  sfr_wdata,
  output logic      [7:0]                  sfr_rdata,
  input  wire logic                        ext_irq_zero_n,
  input  wire logic                        ext_irq_one_n,
  input  wire logic                        timer0_overflow_flag,
  input  wire logic                        timer1_overflow_flag,
  input  wire logic                        timer2_low_overflow_flag,
  input  wire logic                        timer2_high_overflow_flag,
  input  wire logic [ihe_pkg::NUM_SRC-1:0] periph_event,
  input  wire logic [ihe_pkg::NUM_SRC-1:0] flag_set,
  input  wire logic [ihe_pkg::NUM_SRC-1:0] flag_clear,
  input  wire logic [ihe_pkg::NUM_SRC-1:0] prio_high,
  input  wire logic                        instr_done,
  input  wire logic                        instr_single,
  input  wire logic                        return_from_irq_op,
  output logic                             irq_request,
  output logic                             long_call_op,
  output logic      [15:0]                 vector_addr,
  output logic      [3:0]                  vector_src,
  output logic      [7:0]                  int_enable_reg,
  output logic      [7:0]                  extended_int_enable_reg,
  output logic      [ihe_pkg::NUM_SRC-1:0] pending_flags,
  output logic      [1:0]                  service_active
);
  import ihe_pkg::*;

  ihe_state_t        cur;
  ihe_state_t        next_st;
  logic [NUM_SRC-1:0] src_en;
  logic [NUM_SRC-1:0] active;
  logic [NUM_SRC-1:0] req_hi;
  logic [NUM_SRC-1:0] req_lo;
  logic [NUM_SRC-1:0] hw_set;
  logic [NUM_SRC-1:0] auto_clr;
  logic [1:0]         ext_fall;
  logic               gate_ok;
  logic               cand_hi;
  logic               cand_lo;
  logic               take;
  logic [3:0]         sel;
  logic               ie_wr;
  logic               eie_wr;

  // Lowest index wins within a level
  function automatic logic [3:0] first_set(input logic [NUM_SRC-1:0] v);
    logic [3:0] idx;
    idx = 4'h0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        idx = 4'(i);
      end
    end
    return idx;
  endfunction

  function automatic logic [15:0] vec_of(input logic [3:0] idx);
    return VEC_BASE + (16'(idx) << VEC_SHIFT);
  endfunction

  always_comb begin
    ie_wr  = sfr_wr && (sfr_addr == IE_ADDR);
    eie_wr = sfr_wr && (sfr_addr == EIE_ADDR);
    // Active-low external inputs request on a falling edge
    ext_fall = cur.ext_prev & ~cur.ext_sync;
    hw_set = periph_event;
    hw_set[SRC_EX0] = periph_event[SRC_EX0] | ext_fall[0];
    hw_set[SRC_EX1] = periph_event[SRC_EX1] | ext_fall[1];
    hw_set[SRC_T0]  = periph_event[SRC_T0] | timer0_overflow_flag;
    hw_set[SRC_T1]  = periph_event[SRC_T1] | timer1_overflow_flag;
    hw_set[SRC_T2]  = periph_event[SRC_T2] | timer2_low_overflow_flag
                      | timer2_high_overflow_flag;
    src_en = {cur.eie[NUM_EXT_SRC-1:0], 6'h00};
    src_en[SRC_EX0]  = cur.ie[IE_EX0_BIT];
    src_en[SRC_T0]   = cur.ie[IE_T0_BIT];
    src_en[SRC_EX1]  = cur.ie[IE_EX1_BIT];
    src_en[SRC_T1]   = cur.ie[IE_T1_BIT];
    src_en[SRC_UART] = cur.ie[IE_UART_BIT];
    src_en[SRC_T2]   = cur.ie[IE_T2_BIT];
    active = cur.pend & src_en;
    req_hi = active & prio_high;
    req_lo = active & ~prio_high;
    cand_hi = !cur.ins_hi && (|req_hi);
    cand_lo = !cur.ins_hi && !cur.ins_lo && (|req_lo);
    // Gate just cleared: the next single-cycle instruction may still let one in
    gate_ok = cur.ie[IE_GATE_BIT]
              || (cur.lag == LAG_LAST && instr_single);
    irq_request = (cand_hi || cand_lo) && gate_ok && !cur.call;
    // No vectoring on the return itself: one more instruction first
    take = irq_request && instr_done && !return_from_irq_op;
    sel = cand_hi ? first_set(req_hi) : first_set(req_lo);
    auto_clr = '0;
    if (take) begin
      auto_clr[sel] = AUTO_CLR[sel];
    end

    next_st = cur;
    next_st.call = take;
    next_st.ext_meta = {~ext_irq_one_n, ~ext_irq_zero_n};
    next_st.ext_sync = ~cur.ext_meta;
    next_st.ext_prev = cur.ext_sync;
    // Set wins over any clear in the same cycle
    next_st.pend = (cur.pend & ~(flag_clear | auto_clr)) | hw_set | flag_set;
    if (ie_wr) begin
      next_st.ie = sfr_wdata & IE_WMASK;
    end
    if (eie_wr) begin
      next_st.eie = sfr_wdata & EIE_WMASK;
    end
    if (ie_wr && cur.ie[IE_GATE_BIT] && !sfr_wdata[IE_GATE_BIT]) begin
      next_st.lag = instr_done ? LAG_LAST : LAG_ARMED;
    end else if (instr_done && cur.lag != LAG_RESET) begin
      next_st.lag = cur.lag - LAG_LAST;
    end
    if (return_from_irq_op) begin
      if (cur.ins_hi) begin
        next_st.ins_hi = 1'b0;
      end else begin
        next_st.ins_lo = 1'b0;
      end
    end
    if (take) begin
      next_st.vaddr = vec_of(sel);
      next_st.vsrc  = sel;
      if (cand_hi) begin
        next_st.ins_hi = 1'b1;
      end else begin
        next_st.ins_lo = 1'b1;
      end
    end
    if (sfr_rd) begin
      unique case (sfr_addr)
        IE_ADDR:  next_st.rdata = cur.ie;
        EIE_ADDR: next_st.rdata = cur.eie;
        default:  next_st.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cur       <= '0;
      cur.ie    <= IE_RESET;
      cur.eie   <= EIE_RESET;
      cur.lag   <= LAG_RESET;
      cur.ext_meta <= 2'h0;
      cur.ext_sync <= 2'h0;
      cur.ext_prev <= 2'h0;
    end else begin
      cur <= next_st;
    end
  end

  assign sfr_rdata               = cur.rdata;
  assign long_call_op            = cur.call;
  assign vector_addr             = cur.vaddr;
  assign vector_src              = cur.vsrc;
  assign int_enable_reg          = cur.ie;
  assign extended_int_enable_reg = cur.eie;
  assign pending_flags           = cur.pend;
  assign service_active          = {cur.ins_hi, cur.ins_lo};

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  // Event capture and flag clearing
  pend_set_a: assert property (
    timer0_overflow_flag |=> pending_flags[SRC_T0])
    else $error("timer 0 event did not set its pending flag");
  t2_high_set_a: assert property (
    timer2_high_overflow_flag |=> pending_flags[SRC_T2])
    else $error("timer 2 high overflow did not set its pending flag");
  sw_set_a: assert property (
    flag_set[SRC_UART] |=> pending_flags[SRC_UART])
    else $error("software set of a flag was lost");
  clr_pend_a: assert property (
    (flag_clear[SRC_UART] && !flag_set[SRC_UART] && !hw_set[SRC_UART]) |=> !pending_flags[SRC_UART])
    else $error("software clear of a flag was lost");
  auto_clr_a: assert property (
    (take && AUTO_CLR[sel] && !flag_set[sel] && !hw_set[sel]) |=> !pending_flags[$past(sel)])
    else $error("auto-clearing flag survived vectoring");

  // Enables and the global gate
  masked_src_a: assert property (
    (active == '0) |-> !irq_request)
    else $error("request raised with no enabled pending flag");
  src_gate_a: assert property (
    long_call_op |-> $past(src_en[sel]))
    else $error("vectored to a source whose enable was zero");
  gate_block_a: assert property (
    (!int_enable_reg[IE_GATE_BIT] && cur.lag == LAG_RESET) |-> !irq_request)
    else $error("request raised while global gate is zero");
  call_gate_a: assert property (
    long_call_op |-> $past(int_enable_reg[IE_GATE_BIT] || cur.lag == LAG_LAST))
    else $error("vectored with the global gate closed");
  multi_block_a: assert property (
    (!int_enable_reg[IE_GATE_BIT] && !instr_single) |-> !irq_request)
    else $error("request taken after gate clear with multi-cycle follower");
  corner_single_a: assert property (
    (long_call_op && !$past(int_enable_reg[IE_GATE_BIT])) |-> $past(instr_single))
    else $error("corner case taken after a multi-cycle follower");
  lag_expire_a: assert property (
    (cur.lag == LAG_LAST && instr_done && !ie_wr) |=> cur.lag == LAG_RESET)
    else $error("gate-clear window stayed open too long");
  gate_read_a: assert property (
    (ie_wr && !sfr_wdata[IE_GATE_BIT]) |=> !int_enable_reg[IE_GATE_BIT])
    else $error("gate bit still reads one after being cleared");
  ie_write_a: assert property (
    ie_wr |=> int_enable_reg == {$past(sfr_wdata[7]), 1'b0, $past(sfr_wdata[5:0])})
    else $error("enable register write stored wrong value");
  eie_write_a: assert property (
    eie_wr |=> extended_int_enable_reg == {2'h0, $past(sfr_wdata[5:0])})
    else $error("extended enable register write stored wrong value");
  ie_read_a: assert property (
    (sfr_rd && sfr_addr == IE_ADDR) |=> sfr_rdata == $past(int_enable_reg))
    else $error("enable register read returned wrong value");
  t2_mask_a: assert property (
    (long_call_op && vector_src == 4'(SRC_T2)) |-> $past(int_enable_reg[IE_T2_BIT]))
    else $error("timer 2 vectored while its enable was zero");
  t1_mask_a: assert property (
    (long_call_op && vector_src == 4'(SRC_T1)) |-> $past(int_enable_reg[IE_T1_BIT]))
    else $error("timer 1 vectored while its enable was zero");
  t0_mask_a: assert property (
    (long_call_op && vector_src == 4'(SRC_T0)) |-> $past(int_enable_reg[IE_T0_BIT]))
    else $error("timer 0 vectored while its enable was zero");
  ext0_mask_a: assert property (
    (long_call_op && vector_src == 4'(SRC_EX0)) |-> $past(int_enable_reg[IE_EX0_BIT]))
    else $error("external input 0 vectored while its enable was zero");
  ext1_mask_a: assert property (
    (long_call_op && vector_src == 4'(SRC_EX1)) |-> $past(int_enable_reg[IE_EX1_BIT]))
    else $error("external input 1 vectored while its enable was zero");

  // Vectoring, return and nesting
  call_timing_a: assert property (
    (irq_request && instr_done && !return_from_irq_op) |=> long_call_op ##1 !long_call_op)
    else $error("long call not issued one cycle after instruction end");
  call_pulse_a: assert property (
    long_call_op |=> !long_call_op)
    else $error("long call held for more than one cycle");
  vec_value_a: assert property (
    long_call_op |-> vector_addr == VEC_BASE + (16'(vector_src) << VEC_SHIFT))
    else $error("vector address does not match the source");
  return_from_irq_op_hold_a: assert property (
    (return_from_irq_op && instr_done) |=> !long_call_op)
    else $error("routine re-entered on the return itself");
  req_reissue_a: assert property (
    (return_from_irq_op && service_active == 2'h1 && |(active & ~prio_high)
     && int_enable_reg[IE_GATE_BIT] && !sfr_wr && flag_clear == '0)
     |=> irq_request || $changed(prio_high))
    else $error("no new request after return with a flag still set");
  return_from_irq_op_lo_a: assert property (
    (return_from_irq_op && service_active == 2'h1) |=> service_active == 2'h0)
    else $error("return did not end the low-level routine");
  return_from_irq_op_hi_a: assert property (
    (return_from_irq_op && service_active[1]) |=> !service_active[1] && $stable(service_active[0]))
    else $error("return did not end only the high-level routine");
  preempt_a: assert property (
    (take && cand_hi) |=> service_active[1])
    else $error("high-level request did not enter high service");
  hi_busy_a: assert property (
    service_active[1] |=> !long_call_op)
    else $error("vectored while a high-level routine runs");
  lo_busy_a: assert property (
    (service_active == 2'h1) |=> !(long_call_op && service_active == 2'h1))
    else $error("low-level request nested into a low-level routine");

  take_lo_c: cover property (take && !cand_hi);
  nest_hi_c: cover property (service_active == 2'h1 ##[1:50] long_call_op && service_active[1]);
  lag_take_c: cover property (cur.lag == LAG_LAST && take && !int_enable_reg[IE_GATE_BIT]);
  reenter_c: cover property (return_from_irq_op && instr_done ##[1:20] long_call_op);
  lag_block_c: cover property (cur.lag == LAG_LAST && instr_done && !instr_single && cand_lo);

endmodule

//--- ihe_core_model.sv
// Behavioural core sequencer that runs one instruction per request
`timescale 1ns/1ps
module ihe_core_model (
  input  wire logic clk,
  input  wire logic go,
  input  wire logic single,
  input  wire logic ret,
  output logic      instr_done,
  output logic      instr_single,
  output logic      return_from_irq_op
);
  initial begin
    instr_done = 1'b0;
    instr_single = 1'b1;
    return_from_irq_op = 1'b0;
  end
  // Multi-cycle ops take one extra cycle; length bit idles inverted
  always @(posedge clk) begin
    if (go) begin
      if (!single) begin
        @(posedge clk);
      end
      #1;
      instr_done = 1'b1;
      instr_single = single;
      return_from_irq_op = ret;
      @(posedge clk);
      #1;
      instr_done = 1'b0;
      instr_single = ~single;
      return_from_irq_op = 1'b0;
    end
  end
endmodule

//--- ihe_handler_test.sv
// Self-checking bench for the interrupt handler
`timescale 1ns/1ps
module ihe_handler_test;
  import ihe_pkg::*;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [7:0]  wdata = 8'h00;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [12:0] ev = 13'h0000;
  logic [11:0] fset = 12'h000;
  logic [11:0] fclr = 12'h000;
  logic [11:0] prio = 12'h000;
  logic        go = 1'b0;
  logic        single = 1'b1;
  logic        ret = 1'b0;
  logic        done, one, rfi, call, req;
  logic [15:0] vaddr;
  logic [3:0]  vsrc;
  logic [7:0]  rdata, ie, eie;
  logic [11:0] pend;
  logic [1:0]  act;
  int          failures = 0;
  int          cmp_count = 0;
  int          cycles = 0;
  int          s;
  always #5 clk = ~clk;
  ihe_core_model core (.clk(clk), .go(go), .single(single), .ret(ret),
    .instr_done(done), .instr_single(one), .return_from_irq_op(rfi));
  ihe_handler dut (.clk(clk), .reset_n(reset_n), .sfr_addr(addr), .sfr_wr(wr),
    .sfr_rd(rd), .sfr_wdata(wdata), .sfr_rdata(rdata), .ext_irq_zero_n(~ev[0]),
    .ext_irq_one_n(~ev[2]), .timer0_overflow_flag(ev[1]), .timer1_overflow_flag(ev[3]),
    .timer2_low_overflow_flag(ev[5]), .timer2_high_overflow_flag(ev[12]),
    .periph_event(ev[11:0] & 12'hfd0), .flag_set(fset), .flag_clear(fclr),
    .prio_high(prio), .instr_done(done), .instr_single(one), .return_from_irq_op(rfi),
    .irq_request(req), .long_call_op(call), .vector_addr(vaddr), .vector_src(vsrc),
    .int_enable_reg(ie), .extended_int_enable_reg(eie), .pending_flags(pend),
    .service_active(act));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    tick();
    addr = a;
    wdata = d;
    wr = 1'b1;
    tick();
    wr = 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, input logic [7:0] e);
    tick();
    addr = a;
    rd = 1'b1;
    tick();
    rd = 1'b0;
    chk(rdata, e);
  endtask
  task automatic pulse(input logic [12:0] e, input logic [11:0] fs, input logic [11:0] fc);
    tick();
    ev = e;
    fset = fs;
    fclr = fc;
    tick();
    ev = '0;
    fset = '0;
    fclr = '0;
    repeat (4) tick();
  endtask
  // Run one instruction and check whether it vectors
  task automatic instr(input logic s1, input logic r, input logic c, input int src);
    int n;
    n = 0;
    tick();
    go = 1'b1;
    single = s1;
    ret = r;
    tick();
    go = 1'b0;
    do begin
      @(posedge clk);
      n++;
    end while (done !== 1'b1 && n < 4);
    #1;
    chk(call, c);
    if (c) chk(vaddr, VEC_BASE + 16'(src << VEC_SHIFT));
    if (c) chk(vsrc, 16'(src));
  endtask
  task automatic finish_test();
    $display("compares=%0d mismatches=%0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles > 5000) begin
      failures++;
      finish_test();
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    #1;
    reset_n = 1'b1;
    rreg(IE_ADDR, IE_RESET);
    wreg(IE_ADDR, 8'hbf);
    chk(ie, 8'hbf);
    rreg(IE_ADDR, 8'hbf);
    wreg(EIE_ADDR, 8'h3f);
    chk(eie, 8'h3f);
    rreg(EIE_ADDR, 8'h3f);
    rreg(8'h97, 8'h00);
    $display("test registers done");
    for (int k = 0; k < 13; k++) begin
      s = (k == 12) ? SRC_T2 : k;
      wreg(IE_ADDR, 8'h80);
      wreg(EIE_ADDR, 8'h00);
      pulse(13'(1) << k, '0, '0);
      chk(pend[s], 1'b1);
      chk(req, 1'b0);
      instr(1'b1, 1'b0, 1'b0, s);
      if (s < NUM_EXT_SRC) wreg(IE_ADDR, 8'h80 | 8'(1 << s));
      else wreg(EIE_ADDR, 8'(1 << (s - NUM_EXT_SRC)));
      chk(req, 1'b1);
      instr(1'b0, 1'b0, 1'b1, s);
      chk(pend[s], !AUTO_CLR_DEF[s]);
      pulse('0, '0, 12'(1) << s);
      instr(1'b1, 1'b1, 1'b0, s);
      chk(act, 2'h0);
    end
    $display("test sources done");
    wreg(IE_ADDR, 8'h10);
    pulse('0, 12'h010, '0);
    chk(req, 1'b0);
    instr(1'b1, 1'b0, 1'b0, 4);
    wreg(IE_ADDR, 8'h90);
    instr(1'b1, 1'b0, 1'b1, 4);
    instr(1'b1, 1'b1, 1'b0, 4);
    instr(1'b1, 1'b0, 1'b1, 4);
    pulse('0, '0, 12'h010);
    instr(1'b1, 1'b1, 1'b0, 4);
    $display("test gate and reentry done");
    for (int sg = 1; sg >= 0; sg--) begin
      wreg(IE_ADDR, 8'h90);
      wreg(IE_ADDR, 8'h10);
      pulse('0, 12'h010, '0);
      instr(1'b1, 1'b0, 1'b0, 4);
      instr(sg[0], 1'b0, sg[0], 4);
      rreg(IE_ADDR, 8'h10);
      pulse('0, '0, 12'h010);
      if (sg == 1) instr(1'b1, 1'b1, 1'b0, 4);
    end
    $display("test gate corner done");
    wreg(IE_ADDR, 8'h92);
    wreg(EIE_ADDR, 8'h01);
    prio = 12'h040;
    pulse('0, 12'h012, '0);
    instr(1'b1, 1'b0, 1'b1, 1);
    pulse('0, 12'h040, '0);
    instr(1'b1, 1'b0, 1'b1, 6);
    chk(act, 2'h3);
    pulse('0, '0, 12'hfff);
    instr(1'b1, 1'b1, 1'b0, 0);
    instr(1'b1, 1'b1, 1'b0, 0);
    chk(act, 2'h0);
    $display("test priority done");
    finish_test();
  end
endmodule
